// ### sim/srw_host.sv
// host model that toggles the watchdog kick while enabled
`timescale 1ns/1ps
module srw_host (
    input  wire  sys_clk_in,
    input  wire  rst_n_in,
    input  wire  kick_en_in,
    output logic kick_out
);
    logic [5:0] gap;
    // one toggle each 37 cycles, well inside the shortest period
    always @(negedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gap      <= 6'h00;
            kick_out <= 1'b0;
        end else if (kick_en_in) begin
            gap      <= (gap == 6'h24) ? 6'h00 : gap + 6'h01;
            kick_out <= (gap == 6'h24) ? ~kick_out : kick_out;
        end
    end
endmodule

// ### sim/srw_top_asserts.sv
// concurrent checks on the supervisor ports
`timescale 1ns/1ps
`include "srw_defines.vh"
module srw_top_asserts #(
    parameter [`SRW_TICK_W-1:0] TICK_CYCLES = 17'h00004
) (
    input wire sys_clk_in,
    input wire rst_n_in,
    input wire supply_low_in,
    input wire main_above_backup_in,
    input wire supply_sense_low_in,
    input wire watchdog_kick_in,
    input wire kick_floating_in,
    input wire chip_enable_n_in,
    input wire timebase_select_in,
    input wire reset_n_out,
    input wire reset_out,
    input wire watchdog_expired_n_out,
    input wire supply_warn_n_out,
    input wire chip_enable_n_out,
    input wire backup_active_out
);
    reg [1:0]  up;
    reg [15:0] low_cnt;
    // up settles after reset so $past never looks into the reset
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            up      <= 2'h0;
            low_cnt <= 16'h0000;
        end else begin
            up      <= (up == 2'h3) ? up : up + 2'h1;
            low_cnt <= reset_n_out ? 16'h0000 : low_cnt + 16'h0001;
        end
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    inv_reset_a: assert property (reset_out == !reset_n_out)
        else $error("reset outputs not complementary");
    supply_hold_a: assert property (supply_low_in |-> ##2 !reset_n_out)
        else $error("reset not low on low supply");
    ce_gate_a: assert property (up == 2'h3 |=>
        chip_enable_n_out == ($past(supply_low_in) | $past(chip_enable_n_in)))
        else $error("gated chip enable wrong");
    warn_level_a: assert property (up == 2'h3 |=> supply_warn_n_out ==
        !($past(supply_sense_low_in) | ($past(supply_low_in) & !$past(main_above_backup_in))))
        else $error("warning output wrong");
    backup_flag_a: assert property (up == 2'h3 |=>
        backup_active_out == !$past(main_above_backup_in))
        else $error("backup status wrong");
    stretch_len_a: assert property ($rose(reset_n_out) && timebase_select_in |->
        low_cnt >= 49 * TICK_CYCLES)
        else $error("reset pulse too short");
    expiry_reset_a: assert property ($fell(watchdog_expired_n_out) |=> !reset_n_out)
        else $error("no reset after expiry");
    kick_clear_a: assert property (up == 2'h3 && !kick_floating_in && !supply_low_in &&
        watchdog_kick_in != $past(watchdog_kick_in) |-> ##[1:6] watchdog_expired_n_out)
        else $error("expiry not cleared by kick");
    float_off_a: assert property (up == 2'h3 && kick_floating_in &&
        $past(kick_floating_in, 3) |-> watchdog_expired_n_out)
        else $error("expiry while kick floating");
endmodule

// ### sim/srw_top_test.sv
// self-checking bench for the supervisor block
`timescale 1ns/1ps
module srw_top_test;
    logic sys_clk_in = 1'b0, rst_n_in = 1'b0, supply_low_in = 1'b0, backup_near_in = 1'b0;
    logic main_above_backup_in = 1'b1, supply_sense_low_in = 1'b0, kick_floating_in = 1'b1;
    logic chip_enable_n_in = 1'b1, timebase_select_in = 1'b1, timebase_in = 1'b0;
    logic long_pulse_in = 1'b0, short_period_in = 1'b1, kick_en = 1'b0;
    wire  watchdog_kick_in, reset_n_out, reset_out, watchdog_expired_n_out;
    wire  supply_warn_n_out, chip_enable_n_out, backup_active_out;
    wire  [5:0] outs = {reset_n_out, reset_out, watchdog_expired_n_out,
                        supply_warn_n_out, chip_enable_n_out, backup_active_out};
    logic [5:0] exp_q[$];
    logic [31:0] r;
    int   seed = 32'h59AA151E;
    int   fail_count = 0;
    int   checked = 0;
    event look;
    always #4 sys_clk_in = ~sys_clk_in;
    always #64 timebase_in = ~timebase_in;
    srw_top #(.TICK_CYCLES(17'h00004), .EXT_RESET_TICKS(16'h0005),
              .EXT_WDOG_TICKS(16'h0014)) u_dut (
        .sys_clk_in, .rst_n_in, .supply_low_in, .main_above_backup_in, .backup_near_in,
        .supply_sense_low_in, .watchdog_kick_in, .kick_floating_in, .chip_enable_n_in,
        .timebase_select_in, .timebase_in, .long_pulse_in, .short_period_in,
        .reset_n_out, .reset_out, .watchdog_expired_n_out, .supply_warn_n_out,
        .chip_enable_n_out, .backup_active_out);
    srw_host u_host (.sys_clk_in, .rst_n_in, .kick_en_in(kick_en), .kick_out(watchdog_kick_in));
    task conclude();
        $display("counts: %0d checked, %0d failed", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task cmp_out(input logic [5:0] e, input logic [5:0] s);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected outs expected %b seen %b", e, s);
        end
    endtask
    always @(look) cmp_out(exp_q.pop_front(), outs);
    task note(input logic [5:0] e);
        repeat (3) @(negedge sys_clk_in);
        exp_q.push_back(e);
        ->look;
    endtask
    // waits for output bit i to reach v; the wait must end within lo..hi cycles
    task await(input int i, input logic v, input int lo, input int hi);
        int n;
        n = 0;
        while (outs[i] !== v && n < hi) begin
            @(negedge sys_clk_in);
            n++;
        end
        checked++;
        if (outs[i] !== v || n < lo) begin
            fail_count++;
            $display("unexpected wait on out %0d expected %0d..%0d seen %0d", i, lo, hi, n);
            if (outs[i] !== v) conclude();
        end
    endtask
    initial begin
        repeat (2) @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        await(5, 1'b1, 190, 215);
        for (int k = 0; k < 8; k++) begin
            r = $random(seed);
            {chip_enable_n_in, supply_sense_low_in, main_above_backup_in} = r[2:0];
            note({3'h5, ~r[1], r[2], ~r[0]});
        end
        for (int k = 0; k < 4; k++) begin
            r = $random(seed);
            {chip_enable_n_in, supply_sense_low_in, main_above_backup_in} = r[2:0];
            supply_low_in = 1'b1;
            note({3'h3, ~(r[1] | ~r[0]), 1'b1, ~r[0]});
        end
        supply_low_in = 1'b0;
        await(5, 1'b1, 190, 220);
        $display("test supply done");
        kick_floating_in = 1'b0;
        kick_en = 1'b1;
        repeat (1000) @(negedge sys_clk_in);
        note({3'h5, ~r[1], r[2], ~r[0]});
        kick_en = 1'b0;
        await(3, 1'b0, 350, 430);
        await(5, 1'b0, 0, 3);
        await(5, 1'b1, 190, 215);
        await(5, 1'b0, 180, 230);
        kick_en = 1'b1;
        await(3, 1'b1, 0, 45);
        $display("test watchdog done");
        kick_floating_in = 1'b1;
        kick_en = 1'b0;
        repeat (1000) @(negedge sys_clk_in);
        note({3'h5, ~r[1], r[2], ~r[0]});
        long_pulse_in = 1'b1;
        backup_near_in = 1'b1;
        await(5, 1'b0, 1, 4);
        await(5, 1'b1, 790, 815);
        backup_near_in = 1'b0;
        long_pulse_in = 1'b0;
        $display("test near done");
        timebase_select_in = 1'b0;
        kick_floating_in = 1'b0;
        kick_en = 1'b1;
        repeat (100) @(negedge sys_clk_in);
        kick_en = 1'b0;
        await(3, 1'b0, 250, 420);
        await(5, 1'b0, 0, 3);
        await(5, 1'b1, 60, 100);
        $display("test external done");
        conclude();
    end
endmodule
bind srw_top srw_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

// ### src/srw_defines.vh
// constants shared by the supervisor reset and watchdog block
`ifndef SRW_DEFINES_VH
`define SRW_DEFINES_VH

// ----------------------------------------------------------------
// clock and internal timebase
// ----------------------------------------------------------------
`define SRW_CLK_PERIOD_NS   8
`define SRW_TICK_NS         1000000
// 1 ms of 8 ns clock cycles, sized to the prescaler width
`define SRW_TICK_CYCLES     17'h1E848
`define SRW_TICK_W          17
`define SRW_CNT_W           16

// ----------------------------------------------------------------
// times in milliseconds and their counts in timebase ticks
// ----------------------------------------------------------------
`define SRW_RST_SHORT_MS    50
`define SRW_RST_LONG_MS     200
`define SRW_WD_LONG_MS      1600
`define SRW_WD_SHORT_MS     100
// tick counts of 1 ms each, sized to the counter width
`define SRW_RST_SHORT_TICKS 16'h0032
`define SRW_RST_LONG_TICKS  16'h00C8
`define SRW_WD_LONG_TICKS   16'h0640
`define SRW_WD_SHORT_TICKS  16'h0064

// ----------------------------------------------------------------
// external timebase defaults, counted in external clock edges
// ----------------------------------------------------------------
`define SRW_EXT_RESET_TICKS 16'h0032
`define SRW_EXT_WDOG_TICKS  16'h0640

// ----------------------------------------------------------------
// counter reset values and increment constants
// ----------------------------------------------------------------
`define SRW_CNT_ZERO        16'h0000
`define SRW_CNT_ONE         16'h0001
`define SRW_PRE_ZERO        17'h00000
`define SRW_PRE_ONE         17'h00001

`endif

// ### src/srw_sync.v
// two-stage synchroniser with a registered any-edge detector
`timescale 1ns/1ps

module srw_sync (
    input  wire sys_clk_in,
    input  wire rst_n_in,
    input  wire async_in,
    output reg  level_out,
    output reg  edge_out
);

reg stage1;
reg stage2;

always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        stage1    <= 1'b0;
        stage2    <= 1'b0;
        level_out <= 1'b0;
        edge_out  <= 1'b0;
    end else begin
        stage1    <= async_in;
        stage2    <= stage1;
        level_out <= stage2;
        edge_out  <= stage2 ^ level_out;
    end
end

endmodule

// ### src/srw_timebase.v
// timebase tick generator: internal 1 ms prescaler or external clock edges
`timescale 1ns/1ps
`include "srw_defines.vh"

module srw_timebase #(
    parameter [`SRW_TICK_W-1:0] TICK_CYCLES = `SRW_TICK_CYCLES
) (
    input  wire sys_clk_in,
    input  wire rst_n_in,
    input  wire internal_in,
    input  wire timebase_in,
    output reg  tick_out
);

reg [`SRW_TICK_W-1:0] prescale;
reg                   int_tick;
reg                   ext_s1;
reg                   ext_s2;
reg                   ext_s3;

// ----------------------------------------------------------------
// internal oscillator prescaler
// ----------------------------------------------------------------
always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        prescale <= `SRW_PRE_ZERO;
        int_tick <= 1'b0;
    end else if (prescale == TICK_CYCLES - `SRW_PRE_ONE) begin
        prescale <= `SRW_PRE_ZERO;
        int_tick <= 1'b1;
    end else begin
        prescale <= prescale + `SRW_PRE_ONE;
        int_tick <= 1'b0;
    end
end

// ----------------------------------------------------------------
// external timebase: one tick per rising edge
// ----------------------------------------------------------------
always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        ext_s1   <= 1'b0;
        ext_s2   <= 1'b0;
        ext_s3   <= 1'b0;
        tick_out <= 1'b0;
    end else begin
        ext_s1   <= timebase_in;
        ext_s2   <= ext_s1;
        ext_s3   <= ext_s2;
        tick_out <= internal_in ? int_tick : (ext_s2 & ~ext_s3);
    end
end

endmodule

// ### src/srw_top.v
// processor supervisor: supply reset stretch, watchdog, chip-enable gate
//
// Summary of operation
// - Reset output stays low as long as the main supply reads below its threshold.
// - After the supply recovers, reset is held a further 50 ms, or 200 ms in long mode, on the internal timebase; EXT_RESET_TICKS edges on the external one.
// - With no kick edge for a watchdog period, a reset pulse of 50 ms or 200 ms (EXT_RESET_TICKS edges on the external timebase) is issued.
// - While the kick input stays idle, a new reset pulse starts every watchdog period.
// - The expiry output goes low at timeout and stays low until the next kick edge, a floating kick or a low supply.
// - A floating kick input disables the watchdog: no resets and no expiry indication.
// - Gated chip-enable follows its input above threshold and is forced high below it.
// - The warning output is low while the sensed input is below 1.3 V or in backup mode, high otherwise.
// - Timebase select low uses the external timebase; high uses internal 100 ms or 1.6 s.
// - The active-high reset output is always the inverse of the active-low one.
// - Backup supply coming within 50 mV of the main supply triggers a reset pulse.
// - Backup-status output is low while the main supply is above the backup supply.
// - In backup mode kick and chip-enable are ignored, gate and expiry high, warning low.
`timescale 1ns/1ps
`include "srw_defines.vh"

module srw_top #(
    parameter [`SRW_TICK_W-1:0] TICK_CYCLES     = `SRW_TICK_CYCLES,
    parameter [`SRW_CNT_W-1:0]  EXT_RESET_TICKS = `SRW_EXT_RESET_TICKS,
    parameter [`SRW_CNT_W-1:0]  EXT_WDOG_TICKS  = `SRW_EXT_WDOG_TICKS
) (
    input  wire sys_clk_in,
    input  wire rst_n_in,
    input  wire supply_low_in,
    input  wire main_above_backup_in,
    input  wire backup_near_in,
    input  wire supply_sense_low_in,
    input  wire watchdog_kick_in,
    input  wire kick_floating_in,
    input  wire chip_enable_n_in,
    input  wire timebase_select_in,
    input  wire timebase_in,
    input  wire long_pulse_in,
    input  wire short_period_in,
    output reg  reset_n_out,
    output reg  reset_out,
    output reg  watchdog_expired_n_out,
    output reg  supply_warn_n_out,
    output reg  chip_enable_n_out,
    output reg  backup_active_out
);

localparam [`SRW_CNT_W-1:0] RST_SHORT = `SRW_RST_SHORT_TICKS;
localparam [`SRW_CNT_W-1:0] RST_LONG  = `SRW_RST_LONG_TICKS;
localparam [`SRW_CNT_W-1:0] WD_LONG   = `SRW_WD_LONG_TICKS;
localparam [`SRW_CNT_W-1:0] WD_SHORT  = `SRW_WD_SHORT_TICKS;

// terminal count test shared by both timers
function at_end;
    input [`SRW_CNT_W-1:0] count;
    input [`SRW_CNT_W-1:0] limit;
    begin
        at_end = (count == limit - `SRW_CNT_ONE);
    end
endfunction

wire                  tick;
wire                  kick_level;
wire                  kick_edge;
wire                  backup_mode;
wire                  wd_enabled;
wire [`SRW_CNT_W-1:0] reset_ticks;
wire [`SRW_CNT_W-1:0] wd_ticks;
reg  [`SRW_CNT_W-1:0] stretch_cnt;
reg                   pulse_active;
reg  [`SRW_CNT_W-1:0] wd_cnt;
reg                   wd_fire;
reg                   near_prev;
wire                  near_rise;

// ----------------------------------------------------------------
// timebase and kick synchroniser
// ----------------------------------------------------------------
srw_timebase #(
    .TICK_CYCLES (TICK_CYCLES)
) u_timebase (
    .sys_clk_in  (sys_clk_in),
    .rst_n_in    (rst_n_in),
    .internal_in (timebase_select_in),
    .timebase_in (timebase_in),
    .tick_out    (tick)
);

srw_sync u_kick_sync (
    .sys_clk_in (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .async_in   (watchdog_kick_in),
    .level_out  (kick_level),
    .edge_out   (kick_edge)
);

// ----------------------------------------------------------------
// mode and period selection
// ----------------------------------------------------------------
assign backup_mode = supply_low_in & ~main_above_backup_in;
assign wd_enabled  = ~kick_floating_in & ~supply_low_in;
assign reset_ticks = timebase_select_in ? (long_pulse_in ? RST_LONG : RST_SHORT)
                                        : EXT_RESET_TICKS;
assign wd_ticks    = timebase_select_in ? (short_period_in ? WD_SHORT : WD_LONG)
                                        : EXT_WDOG_TICKS;
assign near_rise   = backup_near_in & ~near_prev;

// ----------------------------------------------------------------
// reset pulse stretcher
// ----------------------------------------------------------------
always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        stretch_cnt  <= `SRW_CNT_ZERO;
        pulse_active <= 1'b1;
        near_prev    <= 1'b0;
    end else begin
        near_prev <= backup_near_in;
        if (supply_low_in) begin
            stretch_cnt  <= `SRW_CNT_ZERO;
            pulse_active <= 1'b1;
        end else if (wd_fire || near_rise) begin
            stretch_cnt  <= `SRW_CNT_ZERO;
            pulse_active <= 1'b1;
        end else if (pulse_active && tick) begin
            if (at_end(stretch_cnt, reset_ticks)) begin
                stretch_cnt  <= `SRW_CNT_ZERO;
                pulse_active <= 1'b0;
            end else begin
                stretch_cnt <= stretch_cnt + `SRW_CNT_ONE;
            end
        end
    end
end

// ----------------------------------------------------------------
// watchdog period counter
// ----------------------------------------------------------------
// the counter keeps running through its own reset pulse so that an
// idle kick yields one pulse per watchdog period
always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        wd_cnt  <= `SRW_CNT_ZERO;
        wd_fire <= 1'b0;
    end else if (!wd_enabled || kick_edge) begin
        wd_cnt  <= `SRW_CNT_ZERO;
        wd_fire <= 1'b0;
    end else if (tick && at_end(wd_cnt, wd_ticks)) begin
        wd_cnt  <= `SRW_CNT_ZERO;
        wd_fire <= 1'b1;
    end else begin
        if (tick) begin
            wd_cnt <= wd_cnt + `SRW_CNT_ONE;
        end
        wd_fire <= 1'b0;
    end
end

// ----------------------------------------------------------------
// output registers
// ----------------------------------------------------------------
always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        reset_n_out            <= 1'b0;
        reset_out              <= 1'b1;
        watchdog_expired_n_out <= 1'b1;
        supply_warn_n_out      <= 1'b1;
        chip_enable_n_out      <= 1'b1;
        backup_active_out      <= 1'b0;
    end else begin
        reset_n_out <= ~(supply_low_in | pulse_active);
        reset_out   <= supply_low_in | pulse_active;
        if (!wd_enabled || kick_edge) begin
            watchdog_expired_n_out <= 1'b1;
        end else if (wd_fire) begin
            watchdog_expired_n_out <= 1'b0;
        end
        supply_warn_n_out <= backup_mode ? 1'b0 : ~supply_sense_low_in;
        chip_enable_n_out <= supply_low_in ? 1'b1 : chip_enable_n_in;
        backup_active_out <= ~main_above_backup_in;
    end
end

endmodule
